// *** hw/csrb_pkg.sv ***
package csrb_pkg;

	// DSP register addresses
	localparam logic [15:0] ADDR_IRQ_GATE = 16'hD002;
	localparam logic [15:0] ADDR_EVENTS = 16'hD003;
	localparam logic [15:0] ADDR_STAT_CNT = 16'hD004;
	localparam logic [15:0] ADDR_STAT_MAX = 16'hD005;
	localparam logic [15:0] ADDR_HOST_CFG = 16'hD148;

	// Host port address of the configuration register
	localparam logic [7:0] UP_ADDR_HOST_CFG = 8'h48;

	// Frame-rate and scrambler RAM control fields
	localparam int FRC_RATE_BIT = 9;
	localparam int FRC_RAM_BIT = 8;
	localparam logic FRC_RATE_RST = 1'b0;
	localparam logic FRC_RAM_RST = 1'b0;

	// Interrupt gate, event and statistics fields
	localparam int IRQ_GATE_BIT = 0;
	localparam logic IRQ_GATE_RST = 1'b0;
	localparam int EV_BOTH_BIT = 0;
	localparam int EV_FRAME_BIT = 1;
	localparam int EV_PULSE_BIT = 2;
	localparam logic [7:0] STAT_MAX_RST = 8'h00;
	localparam logic [7:0] STAT_CNT_TOP = 8'hFF;

	// Host interface configuration fields
	localparam int CFG_DMA_EN = 0;
	localparam int CFG_FLY_BY = 1;
	localparam int CFG_PERIPH_XFER = 2;
	localparam int CFG_ACK_PULSE = 3;
	localparam int CFG_IRQ_EN = 4;
	localparam int CFG_IRQ_DRIVE = 5;
	localparam int CFG_IRQ_POL = 6;
	localparam int CFG_DMA_POL = 7;
	localparam int CFG_BUS_MODE = 8;
	localparam logic [7:0] HOST_CFG_RST = 8'h00;

	// Scrambler RAM write masks
	localparam logic [2:0] RAM_MASK_ALL = 3'h7;
	localparam logic [2:0] RAM_MASK_TEST = 3'h1;

	// Frame timing
	localparam int unsigned CLK_HZ = 125000000;
	localparam int unsigned FRAME_LO_HZ = 16000;
	localparam int unsigned FRAME_HI_HZ = 96000;
	localparam int unsigned FRAME_LO_CYC = CLK_HZ / FRAME_LO_HZ;
	localparam int unsigned FRAME_HI_CYC = CLK_HZ / FRAME_HI_HZ;
	localparam int DIV_W = 13;

	typedef enum logic [1:0] {
		CAP_FILL1,
		CAP_FILL2,
		CAP_TAKE,
		CAP_DONE
	} csrb_cap_state_t;

endpackage

// *** hw/csrb_pin_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface csrb_pin_if;
	logic active;
	logic enable;
	logic push_pull;
	logic high_active;
	logic pin_o;
	logic pin_oe_n;

	modport ctrl (output active, output enable, output push_pull, output high_active, input pin_o, input pin_oe_n);
	modport drv (input active, input enable, input push_pull, input high_active, output pin_o, output pin_oe_n);
endinterface
`default_nettype wire

// *** hw/csrb_sync_edge.sv ***
`timescale 1ns/100ps
`default_nettype none
module csrb_sync_edge (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic pin_in,
	output logic level,
	output logic rise
);
	logic meta_ff, nxt_meta;
	logic sync_ff, nxt_sync;
	logic last_ff, nxt_last;
	logic rise_ff, nxt_rise;

	always_comb begin
		nxt_meta = pin_in;
		nxt_sync = meta_ff;
		nxt_last = sync_ff;
		nxt_rise = sync_ff & ~last_ff;
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_ff <= 1'b0;
			sync_ff <= 1'b0;
			last_ff <= 1'b0;
			rise_ff <= 1'b0;
		end else begin
			meta_ff <= nxt_meta;
			sync_ff <= nxt_sync;
			last_ff <= nxt_last;
			rise_ff <= nxt_rise;
		end
	end

	assign level = sync_ff;
	assign rise = rise_ff;
endmodule
`default_nettype wire

// *** hw/csrb_irq_pin.sv ***
`timescale 1ns/100ps
`default_nettype none
module csrb_irq_pin (
	input wire logic ref_clk,
	input wire logic reset_n,
	csrb_pin_if.drv pin
);
	logic pin_o_ff, nxt_pin_o;
	logic pin_oe_n_ff, nxt_pin_oe_n;
	logic asserted;
	logic level;

	always_comb begin
		asserted = pin.active & pin.enable;
		level = pin.high_active ? asserted : ~asserted;
		if (pin.push_pull) begin
			nxt_pin_o = level;
			nxt_pin_oe_n = 1'b0;
		end else begin
			// Open drain only pulls low
			nxt_pin_o = 1'b0;
			nxt_pin_oe_n = level;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			pin_o_ff <= 1'b0;
			pin_oe_n_ff <= 1'b1;
		end else begin
			pin_o_ff <= nxt_pin_o;
			pin_oe_n_ff <= nxt_pin_oe_n;
		end
	end

	assign pin.pin_o = pin_o_ff;
	assign pin.pin_oe_n = pin_oe_n_ff;
endmodule
`default_nettype wire

// *** hw/csrb_reg_bank.sv ***
// How it works
// - Frame tick 16 kHz or 96 kHz
// - Test mode lets only first RAM write
// - Frame-rate register DSP write-only, bits reset 0
// - Mask bit gates serial interrupt, resets 0
// - Undefined bits read zero
// - Frame sync rise sets flag 1
// - Flag 0 when both flags set
// - Counter survives reset, clears at next frame sync rise after read
// - Max count register, low byte, resets 0
// - Bit 0 DMA, bit 1 fly-by
// - Bit 2 enables peripheral event transfers
// - Bit 3 picks acknowledge pulse for vector
// - Bit 5 drive mode, bit 6 level
// - Bit 8 bus mode captured after reset release
`timescale 1ns/100ps
`default_nettype none
module csrb_reg_bank #(
	parameter int unsigned FRAME_LO_CYC = csrb_pkg::FRAME_LO_CYC
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic [15:0] dsp_addr,
	input wire logic dsp_rd,
	input wire logic dsp_wr,
	input wire logic [15:0] dsp_wdata,
	output logic [15:0] dsp_rdata,
	input wire logic frc_wr,
	input wire logic [15:0] frc_wdata,
	input wire logic [7:0] up_addr,
	input wire logic up_rd,
	input wire logic up_wr,
	input wire logic [7:0] up_wdata,
	output logic [7:0] up_rdata,
	input wire logic frame_sync_pin,
	input wire logic pulse_frame_sync_pin,
	input wire logic bus_mode_pin,
	input wire logic serial_ctrl_irq_src,
	output logic serial_ctrl_irq,
	input wire logic stat_event,
	output logic stat_max_reached,
	input wire logic [2:0] scrambler_ram_wr_req,
	output logic [2:0] scrambler_ram_wr_allow,
	output logic frame_rate_sel,
	output logic scram_ram_wr_en,
	output logic serial_frame_tick,
	output logic dma_en,
	output logic fly_by_sel,
	output logic periph_event_xfer_en,
	output logic ack_pulse_sel,
	output logic bus_mode,
	input wire logic dma_req_rx_src,
	input wire logic dma_req_tx_src,
	output logic dma_req_rx,
	output logic dma_req_tx,
	input wire logic irq_src,
	output logic irq_out_pin_o,
	output logic irq_out_pin_oe_n
);
	localparam logic [12:0] LO_LAST = 13'(FRAME_LO_CYC - 1);
	localparam logic [12:0] HI_LAST = 13'(csrb_pkg::FRAME_HI_CYC - 1);

	function automatic logic dsp_hit(input logic [15:0] addr, input logic [15:0] reg_addr);
		dsp_hit = (addr == reg_addr);
	endfunction

	// Synchronised pins
	logic frame_sync_lvl, frame_sync_rise;
	logic pulse_frame_sync_lvl, pulse_frame_sync_rise;
	logic bus_mode_lvl;

	csrb_sync_edge u_frame_sync (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.pin_in(frame_sync_pin),
		.level(frame_sync_lvl),
		.rise(frame_sync_rise)
	);

	csrb_sync_edge u_pulse_sync (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.pin_in(pulse_frame_sync_pin),
		.level(pulse_frame_sync_lvl),
		.rise(pulse_frame_sync_rise)
	);

	csrb_sync_edge u_bus_mode (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.pin_in(bus_mode_pin),
		.level(bus_mode_lvl),
		.rise()
	);

	logic dsp_rd_events, dsp_rd_stat;
	assign dsp_rd_events = dsp_rd & dsp_hit(dsp_addr, csrb_pkg::ADDR_EVENTS);
	assign dsp_rd_stat = dsp_rd & dsp_hit(dsp_addr, csrb_pkg::ADDR_STAT_CNT);

	// Control registers
	logic frame_rate_ff, nxt_frame_rate;
	logic ram_wr_en_ff, nxt_ram_wr_en;
	logic irq_gate_ff, nxt_irq_gate;
	logic [7:0] stat_max_ff, nxt_stat_max;
	logic [7:0] host_cfg_ff, nxt_host_cfg;

	always_comb begin
		nxt_frame_rate = frame_rate_ff;
		nxt_ram_wr_en = ram_wr_en_ff;
		nxt_irq_gate = irq_gate_ff;
		nxt_stat_max = stat_max_ff;
		nxt_host_cfg = host_cfg_ff;
		if (frc_wr) begin
			nxt_frame_rate = frc_wdata[csrb_pkg::FRC_RATE_BIT];
			nxt_ram_wr_en = frc_wdata[csrb_pkg::FRC_RAM_BIT];
		end
		if (dsp_wr) begin
			if (dsp_hit(dsp_addr, csrb_pkg::ADDR_IRQ_GATE)) begin
				nxt_irq_gate = dsp_wdata[csrb_pkg::IRQ_GATE_BIT];
			end else if (dsp_hit(dsp_addr, csrb_pkg::ADDR_STAT_MAX)) begin
				nxt_stat_max = dsp_wdata[7:0];
			end
		end
		if (up_wr && up_addr == csrb_pkg::UP_ADDR_HOST_CFG) begin
			nxt_host_cfg = up_wdata;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			frame_rate_ff <= csrb_pkg::FRC_RATE_RST;
			ram_wr_en_ff <= csrb_pkg::FRC_RAM_RST;
			irq_gate_ff <= csrb_pkg::IRQ_GATE_RST;
			stat_max_ff <= csrb_pkg::STAT_MAX_RST;
			host_cfg_ff <= csrb_pkg::HOST_CFG_RST;
		end else begin
			frame_rate_ff <= nxt_frame_rate;
			ram_wr_en_ff <= nxt_ram_wr_en;
			irq_gate_ff <= nxt_irq_gate;
			stat_max_ff <= nxt_stat_max;
			host_cfg_ff <= nxt_host_cfg;
		end
	end

	// Bus mode capture after reset release
	csrb_pkg::csrb_cap_state_t cap_ff, nxt_cap;
	logic bus_mode_ff, nxt_bus_mode;

	always_comb begin
		nxt_cap = cap_ff;
		nxt_bus_mode = bus_mode_ff;
		case (cap_ff)
			csrb_pkg::CAP_FILL1: begin
				nxt_cap = csrb_pkg::CAP_FILL2;
			end
			csrb_pkg::CAP_FILL2: begin
				nxt_cap = csrb_pkg::CAP_TAKE;
			end
			csrb_pkg::CAP_TAKE: begin
				nxt_bus_mode = bus_mode_lvl;
				nxt_cap = csrb_pkg::CAP_DONE;
			end
			default: begin
				nxt_cap = csrb_pkg::CAP_DONE;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			cap_ff <= csrb_pkg::CAP_FILL1;
			bus_mode_ff <= 1'b0;
		end else begin
			cap_ff <= nxt_cap;
			bus_mode_ff <= nxt_bus_mode;
		end
	end

	// Sticky sync event flags
	logic ev_frame_ff, nxt_ev_frame;
	logic ev_pulse_ff, nxt_ev_pulse;
	logic ev_both_ff, nxt_ev_both;

	always_comb begin
		nxt_ev_frame = frame_sync_rise | (ev_frame_ff & ~dsp_rd_events);
		nxt_ev_pulse = pulse_frame_sync_rise | (ev_pulse_ff & ~dsp_rd_events);
		nxt_ev_both = (nxt_ev_frame & nxt_ev_pulse) | (ev_both_ff & ~dsp_rd_events);
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			ev_frame_ff <= 1'b0;
			ev_pulse_ff <= 1'b0;
			ev_both_ff <= 1'b0;
		end else begin
			ev_frame_ff <= nxt_ev_frame;
			ev_pulse_ff <= nxt_ev_pulse;
			ev_both_ff <= nxt_ev_both;
		end
	end

	// Statistics counter, deliberately not reset
	logic [7:0] stat_cnt_ff, nxt_stat_cnt;
	logic stat_read_ff, nxt_stat_read;
	logic stat_max_hit_ff, nxt_stat_max_hit;

	always_comb begin
		nxt_stat_cnt = stat_cnt_ff;
		nxt_stat_read = stat_read_ff | dsp_rd_stat;
		if (dsp_wr && dsp_hit(dsp_addr, csrb_pkg::ADDR_STAT_CNT)) begin
			nxt_stat_cnt = dsp_wdata[7:0];
		end else if (frame_sync_rise && stat_read_ff) begin
			nxt_stat_cnt = 8'h00;
		end else if (stat_event && stat_cnt_ff != csrb_pkg::STAT_CNT_TOP) begin
			nxt_stat_cnt = stat_cnt_ff + 8'h01;
		end
		if (frame_sync_rise) begin
			nxt_stat_read = dsp_rd_stat;
		end
		nxt_stat_max_hit = (stat_cnt_ff >= stat_max_ff);
	end

	always_ff @(posedge ref_clk) begin
		stat_cnt_ff <= nxt_stat_cnt;
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			stat_read_ff <= 1'b0;
			stat_max_hit_ff <= 1'b0;
		end else begin
			stat_read_ff <= nxt_stat_read;
			stat_max_hit_ff <= nxt_stat_max_hit;
		end
	end

	// Serial controller frame divider
	logic [12:0] div_ff, nxt_div;
	logic tick_ff, nxt_tick;
	logic [12:0] div_last;

	always_comb begin
		div_last = frame_rate_ff ? HI_LAST : LO_LAST;
		if (div_ff >= div_last) begin
			nxt_div = 13'h0000;
			nxt_tick = 1'b1;
		end else begin
			nxt_div = div_ff + 13'h0001;
			nxt_tick = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			div_ff <= 13'h0000;
			tick_ff <= 1'b0;
		end else begin
			div_ff <= nxt_div;
			tick_ff <= nxt_tick;
		end
	end

	// Read data and gated outputs
	logic [15:0] dsp_rdata_ff, nxt_dsp_rdata;
	logic [7:0] up_rdata_ff, nxt_up_rdata;
	logic serial_irq_ff, nxt_serial_irq;
	logic [2:0] ram_allow_ff, nxt_ram_allow;
	logic dma_rx_ff, nxt_dma_rx;
	logic dma_tx_ff, nxt_dma_tx;
	logic [15:0] cfg_word;

	always_comb begin
		cfg_word = 16'h0000;
		cfg_word[7:0] = host_cfg_ff;
		cfg_word[csrb_pkg::CFG_BUS_MODE] = bus_mode_ff;
		nxt_dsp_rdata = 16'h0000;
		if (dsp_rd) begin
			if (dsp_hit(dsp_addr, csrb_pkg::ADDR_IRQ_GATE)) begin
				nxt_dsp_rdata[csrb_pkg::IRQ_GATE_BIT] = irq_gate_ff;
			end else if (dsp_hit(dsp_addr, csrb_pkg::ADDR_EVENTS)) begin
				nxt_dsp_rdata[csrb_pkg::EV_BOTH_BIT] = ev_both_ff;
				nxt_dsp_rdata[csrb_pkg::EV_FRAME_BIT] = ev_frame_ff;
				nxt_dsp_rdata[csrb_pkg::EV_PULSE_BIT] = ev_pulse_ff;
			end else if (dsp_hit(dsp_addr, csrb_pkg::ADDR_STAT_CNT)) begin
				nxt_dsp_rdata[7:0] = stat_cnt_ff;
			end else if (dsp_hit(dsp_addr, csrb_pkg::ADDR_STAT_MAX)) begin
				nxt_dsp_rdata[7:0] = stat_max_ff;
			end else if (dsp_hit(dsp_addr, csrb_pkg::ADDR_HOST_CFG)) begin
				nxt_dsp_rdata = cfg_word;
			end
		end
		nxt_up_rdata = 8'h00;
		if (up_rd && up_addr == csrb_pkg::UP_ADDR_HOST_CFG) begin
			nxt_up_rdata = host_cfg_ff;
		end
		nxt_serial_irq = serial_ctrl_irq_src & irq_gate_ff;
		nxt_ram_allow = scrambler_ram_wr_req
			& (ram_wr_en_ff ? csrb_pkg::RAM_MASK_ALL : csrb_pkg::RAM_MASK_TEST);
		nxt_dma_rx = dma_req_rx_src ^ host_cfg_ff[csrb_pkg::CFG_DMA_POL];
		nxt_dma_tx = dma_req_tx_src ^ host_cfg_ff[csrb_pkg::CFG_DMA_POL];
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			dsp_rdata_ff <= 16'h0000;
			up_rdata_ff <= 8'h00;
			serial_irq_ff <= 1'b0;
			ram_allow_ff <= 3'h0;
			dma_rx_ff <= 1'b0;
			dma_tx_ff <= 1'b0;
		end else begin
			dsp_rdata_ff <= nxt_dsp_rdata;
			up_rdata_ff <= nxt_up_rdata;
			serial_irq_ff <= nxt_serial_irq;
			ram_allow_ff <= nxt_ram_allow;
			dma_rx_ff <= nxt_dma_rx;
			dma_tx_ff <= nxt_dma_tx;
		end
	end

	// Interrupt request pin
	csrb_pin_if irq_pin ();

	assign irq_pin.active = irq_src;
	assign irq_pin.enable = host_cfg_ff[csrb_pkg::CFG_IRQ_EN];
	assign irq_pin.push_pull = host_cfg_ff[csrb_pkg::CFG_IRQ_DRIVE];
	assign irq_pin.high_active = host_cfg_ff[csrb_pkg::CFG_IRQ_POL];

	csrb_irq_pin u_irq_pin (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.pin(irq_pin.drv)
	);

	assign irq_out_pin_o = irq_pin.pin_o;
	assign irq_out_pin_oe_n = irq_pin.pin_oe_n;

	assign dsp_rdata = dsp_rdata_ff;
	assign up_rdata = up_rdata_ff;
	assign serial_ctrl_irq = serial_irq_ff;
	assign stat_max_reached = stat_max_hit_ff;
	assign scrambler_ram_wr_allow = ram_allow_ff;
	assign frame_rate_sel = frame_rate_ff;
	assign scram_ram_wr_en = ram_wr_en_ff;
	assign serial_frame_tick = tick_ff;
	assign dma_en = host_cfg_ff[csrb_pkg::CFG_DMA_EN];
	assign fly_by_sel = host_cfg_ff[csrb_pkg::CFG_FLY_BY];
	assign periph_event_xfer_en = host_cfg_ff[csrb_pkg::CFG_PERIPH_XFER];
	assign ack_pulse_sel = host_cfg_ff[csrb_pkg::CFG_ACK_PULSE];
	assign bus_mode = bus_mode_ff;
	assign dma_req_rx = dma_rx_ff;
	assign dma_req_tx = dma_tx_ff;
endmodule
`default_nettype wire

// *** verification/csrb_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module csrb_host_model (
	input wire logic ref_clk,
	output logic [7:0] up_addr,
	output logic up_rd,
	output logic up_wr,
	output logic [7:0] up_wdata,
	input wire logic [7:0] up_rdata
);
	initial begin
		up_addr = 8'h00;
		up_rd = 1'b0;
		up_wr = 1'b0;
		up_wdata = 8'h00;
	end

	// Released lines show the inverse, never a stale value
	task host_write(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		up_addr <= a;
		up_wdata <= d;
		up_wr <= 1'b1;
		@(posedge ref_clk);
		up_wr <= 1'b0;
		up_addr <= ~a;
		up_wdata <= ~d;
	endtask

	task host_read(input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		up_addr <= a;
		up_rd <= 1'b1;
		@(posedge ref_clk);
		up_rd <= 1'b0;
		up_addr <= ~a;
		#1;
		d = up_rdata;
	endtask
endmodule
`default_nettype wire

// *** verification/csrb_reg_bank_props.sv ***
`timescale 1ns/100ps
`default_nettype none
module csrb_reg_bank_props (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic [15:0] dsp_addr,
	input wire logic dsp_rd,
	input wire logic [15:0] dsp_rdata,
	input wire logic frc_wr,
	input wire logic [15:0] frc_wdata,
	input wire logic [7:0] up_addr,
	input wire logic up_wr,
	input wire logic [7:0] up_wdata,
	input wire logic serial_ctrl_irq_src,
	input wire logic serial_ctrl_irq,
	input wire logic [2:0] scrambler_ram_wr_req,
	input wire logic [2:0] scrambler_ram_wr_allow,
	input wire logic frame_rate_sel,
	input wire logic scram_ram_wr_en,
	input wire logic dma_en,
	input wire logic fly_by_sel,
	input wire logic periph_event_xfer_en,
	input wire logic ack_pulse_sel,
	input wire logic dma_req_rx_src,
	input wire logic dma_req_tx_src,
	input wire logic dma_req_rx,
	input wire logic dma_req_tx,
	input wire logic irq_out_pin_o,
	input wire logic irq_out_pin_oe_n
);
	// Polarity bit as last written over the host port
	logic dma_pol_ff;

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			dma_pol_ff <= 1'b0;
		end else if (up_wr && up_addr == 8'h48) begin
			dma_pol_ff <= up_wdata[7];
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	AST_IRQ_GATE: assert property (serial_ctrl_irq |-> $past(serial_ctrl_irq_src))
		else $error("serial interrupt without source");
	AST_RAM_ALLOW: assert property ($past(reset_n) |-> scrambler_ram_wr_allow ==
		($past(scrambler_ram_wr_req) & {{2{$past(scram_ram_wr_en)}}, 1'b1}))
		else $error("scrambler ram write allow wrong");
	AST_FRC_WRITE: assert property (frc_wr |=> {frame_rate_sel, scram_ram_wr_en} == $past(frc_wdata[9:8]))
		else $error("control bits not taken");
	AST_RDATA_IDLE: assert property (!dsp_rd |=> dsp_rdata == 16'h0000)
		else $error("read data without read");
	AST_UNDEF_ZERO: assert property (dsp_rd && dsp_addr inside {16'hD004, 16'hD005} |=> dsp_rdata[15:8] == 8'h00)
		else $error("undefined count bits not zero");
	AST_MASK_UNDEF: assert property (dsp_rd && dsp_addr == 16'hD002 |=> dsp_rdata[15:1] == 15'h0000)
		else $error("undefined mask bits not zero");
	AST_BOTH_FLAG: assert property (dsp_rd && dsp_addr == 16'hD003 |=> !dsp_rdata[0] || dsp_rdata[2:1] == 2'h3)
		else $error("both flag without both edges");
	AST_CFG_WRITE: assert property (up_wr && up_addr == 8'h48 |=>
		{ack_pulse_sel, periph_event_xfer_en, fly_by_sel, dma_en} == $past(up_wdata[3:0]))
		else $error("config bits not taken");
	AST_DMA_POL: assert property ($past(reset_n) |-> dma_req_rx == ($past(dma_req_rx_src) ^ $past(dma_pol_ff))
		&& dma_req_tx == ($past(dma_req_tx_src) ^ $past(dma_pol_ff)))
		else $error("dma request polarity differs");
	AST_PIN_DRIVE: assert property (irq_out_pin_o |-> !irq_out_pin_oe_n)
		else $error("pin high while not driven");

	COV_FRC: cover property (frc_wr ##1 frame_rate_sel);
	COV_CFG: cover property (up_wr && up_addr == 8'h48);
	COV_BOTH: cover property (dsp_rd && dsp_addr == 16'hD003 ##1 dsp_rdata[0]);
endmodule

bind csrb_reg_bank csrb_reg_bank_props props_u (.ref_clk, .reset_n, .dsp_addr, .dsp_rd, .dsp_rdata, .frc_wr,
	.frc_wdata, .up_addr, .up_wr, .up_wdata, .serial_ctrl_irq_src, .serial_ctrl_irq, .scrambler_ram_wr_req,
	.scrambler_ram_wr_allow, .frame_rate_sel, .scram_ram_wr_en, .dma_en, .fly_by_sel, .periph_event_xfer_en,
	.ack_pulse_sel, .dma_req_rx_src, .dma_req_tx_src, .dma_req_rx, .dma_req_tx, .irq_out_pin_o, .irq_out_pin_oe_n);
`default_nettype wire

// *** verification/tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb;
	localparam int LO_CYC = 20;
	logic ref_clk, reset_n, dsp_rd, dsp_wr, frc_wr, up_rd, up_wr, frame_sync_pin, pulse_frame_sync_pin;
	logic bus_mode_pin, serial_ctrl_irq_src, serial_ctrl_irq, stat_event, stat_max_reached, frame_rate_sel;
	logic scram_ram_wr_en, serial_frame_tick, dma_en, fly_by_sel, periph_event_xfer_en, ack_pulse_sel, bus_mode;
	logic dma_req_rx_src, dma_req_tx_src, dma_req_rx, dma_req_tx, irq_src, irq_out_pin_o, irq_out_pin_oe_n;
	logic [15:0] dsp_addr, dsp_wdata, dsp_rdata, frc_wdata;
	logic [7:0] up_addr, up_wdata, up_rdata, h;
	logic [2:0] scrambler_ram_wr_req, scrambler_ram_wr_allow;
	logic [15:0] t;
	logic lv;
	int failures = 0;
	int num_checks = 0;
	int n;

	csrb_reg_bank #(.FRAME_LO_CYC(LO_CYC)) dut_u (.ref_clk, .reset_n, .dsp_addr, .dsp_rd, .dsp_wr, .dsp_wdata,
		.dsp_rdata, .frc_wr, .frc_wdata, .up_addr, .up_rd, .up_wr, .up_wdata, .up_rdata, .frame_sync_pin,
		.pulse_frame_sync_pin, .bus_mode_pin, .serial_ctrl_irq_src, .serial_ctrl_irq, .stat_event,
		.stat_max_reached, .scrambler_ram_wr_req, .scrambler_ram_wr_allow, .frame_rate_sel, .scram_ram_wr_en,
		.serial_frame_tick, .dma_en, .fly_by_sel, .periph_event_xfer_en, .ack_pulse_sel, .bus_mode,
		.dma_req_rx_src, .dma_req_tx_src, .dma_req_rx, .dma_req_tx, .irq_src, .irq_out_pin_o, .irq_out_pin_oe_n);
	csrb_host_model host_u (.ref_clk, .up_addr, .up_rd, .up_wr, .up_wdata, .up_rdata);

	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	task give_verdict();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task check(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task clk(input int k);
		repeat (k) @(posedge ref_clk);
		#1;
	endtask

	task dsp_write(input logic [15:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		dsp_addr <= a;
		dsp_wdata <= d;
		dsp_wr <= 1'b1;
		@(posedge ref_clk);
		dsp_wr <= 1'b0;
		dsp_addr <= ~a;
		dsp_wdata <= ~d;
	endtask

	task dsp_read(input logic [15:0] a, output logic [15:0] d);
		@(posedge ref_clk);
		dsp_addr <= a;
		dsp_rd <= 1'b1;
		@(posedge ref_clk);
		dsp_rd <= 1'b0;
		dsp_addr <= ~a;
		#1;
		d = dsp_rdata;
	endtask

	task frc_set(input logic [15:0] d);
		@(posedge ref_clk);
		frc_wdata <= d;
		frc_wr <= 1'b1;
		@(posedge ref_clk);
		frc_wr <= 1'b0;
		frc_wdata <= ~d;
	endtask

	task sync_rise(input logic fs, input logic pulse_frame_sync);
		@(posedge ref_clk);
		frame_sync_pin <= fs;
		pulse_frame_sync_pin <= pulse_frame_sync;
		repeat (3) @(posedge ref_clk);
		frame_sync_pin <= 1'b0;
		pulse_frame_sync_pin <= 1'b0;
		repeat (3) @(posedge ref_clk);
	endtask

	task stat_pulse();
		@(posedge ref_clk);
		stat_event <= 1'b1;
		@(posedge ref_clk);
		stat_event <= 1'b0;
	endtask

	// Cycles between two frame ticks, bounded
	task tick_gap(output int g);
		clk(1);
		for (int k = 0; k < 3000 && serial_frame_tick !== 1'b1; k++) clk(1);
		g = 0;
		do begin
			clk(1);
			g++;
		end while (serial_frame_tick !== 1'b1 && g < 3000);
	endtask

	initial begin
		repeat (20000) @(posedge ref_clk);
		failures++;
		give_verdict();
	end

	initial begin
		{reset_n, dsp_rd, dsp_wr, frc_wr, frame_sync_pin, pulse_frame_sync_pin, stat_event} = '0;
		{serial_ctrl_irq_src, dma_req_rx_src, dma_req_tx_src, irq_src, scrambler_ram_wr_req} = '0;
		{dsp_addr, dsp_wdata, frc_wdata} = '0;
		bus_mode_pin = 1'b1;
		clk(5);
		reset_n <= 1'b1;
		clk(6);
		check(bus_mode, 1);
		check({frame_rate_sel, scram_ram_wr_en}, 0);
		bus_mode_pin <= 1'b0;
		dsp_read(16'hD002, t);
		check(t, 16'h0000);
		dsp_read(16'hD005, t);
		check(t, 16'h0000);
		dsp_read(16'hD003, t);
		check(t, 16'h0000);
		host_u.host_read(8'h48, h);
		check(h, 8'h00);
		dsp_read(16'hD148, t);
		check(t, 16'h0100);
		dsp_read(16'hD006, t);
		check(t, 16'h0000);
		serial_ctrl_irq_src <= 1'b1;
		clk(2);
		check(serial_ctrl_irq, 0);
		dsp_write(16'hD002, 16'hFFFF);
		dsp_read(16'hD002, t);
		check(t, 16'h0001);
		check(serial_ctrl_irq, 1);
		dsp_write(16'hD005, 16'h01AB);
		dsp_read(16'hD005, t);
		check(t, 16'h00AB);
		dsp_write(16'hD004, 16'h0005);
		repeat (3) stat_pulse();
		dsp_read(16'hD004, t);
		check(t, 16'h0008);
		sync_rise(1, 0);
		dsp_read(16'hD004, t);
		check(t, 16'h0000);
		sync_rise(1, 0);
		dsp_write(16'hD005, 16'h0002);
		repeat (2) stat_pulse();
		sync_rise(1, 0);
		check(stat_max_reached, 1);
		dsp_read(16'hD004, t);
		check(t, 16'h0002);
		sync_rise(1, 0);
		dsp_read(16'hD004, t);
		check(t, 16'h0000);
		dsp_write(16'hD004, 16'h0033);
		reset_n <= 1'b0;
		clk(3);
		reset_n <= 1'b1;
		clk(5);
		check(bus_mode, 0);
		dsp_read(16'hD004, t);
		check(t, 16'h0033);
		dsp_read(16'hD003, t);
		sync_rise(0, 1);
		dsp_read(16'hD003, t);
		check(t, 16'h0004);
		sync_rise(1, 0);
		dsp_read(16'hD003, t);
		check(t, 16'h0002);
		dsp_read(16'hD003, t);
		check(t, 16'h0000);
		sync_rise(1, 1);
		dsp_read(16'hD003, t);
		check(t, 16'h0007);
		@(posedge ref_clk);
		pulse_frame_sync_pin <= 1'b1;
		repeat (2) @(posedge ref_clk);
		dsp_read(16'hD003, t);
		pulse_frame_sync_pin <= 1'b0;
		dsp_read(16'hD003, t);
		check(t, 16'h0004);
		for (int i = 0; i < 4; i++) begin
			host_u.host_write(8'h48, 8'h01 << i);
			clk(1);
			check({ack_pulse_sel, periph_event_xfer_en, fly_by_sel, dma_en}, 16'h0001 << i);
			host_u.host_read(8'h48, h);
			check(h, 8'h01 << i);
		end
		dma_req_rx_src <= 1'b1;
		host_u.host_write(8'h48, 8'h00);
		clk(2);
		check({dma_req_rx, dma_req_tx}, 16'h0002);
		host_u.host_write(8'h48, 8'h80);
		clk(2);
		check({dma_req_rx, dma_req_tx}, 16'h0001);
		irq_src <= 1'b1;
		for (int j = 0; j < 8; j++) begin
			host_u.host_write(8'h48, 8'(j << 4));
			clk(2);
			lv = j[2] ? j[0] : !j[0];
			check({irq_out_pin_o, irq_out_pin_oe_n}, j[1] ? {lv, 1'b0} : {1'b0, lv});
		end
		scrambler_ram_wr_req <= 3'h7;
		frc_set(16'h0000);
		clk(2);
		check(scrambler_ram_wr_allow, 16'h0001);
		frc_set(16'h0100);
		clk(2);
		check(scrambler_ram_wr_allow, 16'h0007);
		tick_gap(n);
		check(n[15:0], LO_CYC);
		frc_set(16'h0300);
		tick_gap(n);
		check(n[15:0], 16'd1302);
		check(frame_rate_sel, 1);
		give_verdict();
	end
endmodule
`default_nettype wire
